// ==== core/adc_calc_pkg.sv ====
// Constants, types and register map of the post-conversion computation unit.
// Assumes a 32-bit Avalon-MM register port with byte addresses.
package adc_calc_pkg;
  localparam int ADDR_W = 8;
  localparam int ACC_W = 20;
  localparam int RES_W = 12;
  localparam int FILT_W = 16;
  localparam int LPF_SHIFT = 2;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RPT = 8'h04;
  localparam logic [7:0] OFS_CNT = 8'h08;
  localparam logic [7:0] OFS_CHAN = 8'h0C;
  localparam logic [7:0] OFS_RESH = 8'h10;
  localparam logic [7:0] OFS_RESL = 8'h14;
  localparam logic [7:0] OFS_ACC = 8'h18;
  localparam logic [7:0] OFS_FILT = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  localparam logic [7:0] OFS_THR = 8'h28;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DSE_BIT = 3;
  localparam int CTRL_FM_BIT = 4;
  localparam int CTRL_TRIG_EN_BIT = 5;
  localparam int CTRL_ABOVE_BIT = 6;
  localparam int CTRL_CLR_BIT = 7;
  localparam int CTRL_GO_BIT = 8;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_THR_BIT = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RPT_RST = 8'h01;
  localparam logic [5:0] CHAN_RST = 6'h00;
  localparam logic [ACC_W-1:0] THR_RST = 20'h00000;

  // Mode field encoding.
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUM = 3'h1;
  localparam logic [2:0] MODE_AVG = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LPF = 3'h4;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } seq_state_type;

  typedef struct packed {
    logic start;
    logic [5:0] channel;
  } conv_req_type;

  typedef struct packed {
    logic done;
    logic [RES_W-1:0] data;
  } conv_rsp_type;
endpackage : adc_calc_pkg

// ==== core/adc_calc_unit.sv ====
// Post-conversion computation unit with Avalon-MM register slave and interrupt.
// Assumes the conversion core runs on sys_clk_i and answers each start with one done pulse.
// How it works
// [R01] The three-bit mode field of the control register picks one of five computation modes.
// [R02] Basic mode runs one conversion per trigger, or two when double sampling is enabled.
// [R03] Basic mode raises the done flag only after the last conversion of the trigger.
// [R04] Accumulate mode adds each result into the accumulator and bumps the sample count.
// [R05] Accumulate mode raises done on every conversion and tests the threshold as configured.
// [R06] Average mode accumulates and tests once the repeat count of samples is reached.
// [R07] Average mode clears the accumulator on the trigger after a test and needs a full count again.
// [R08] Burst mode clears on the trigger, converts until the repeat count, then tests once.
// [R09] Filter mode filters every result and first tests when the repeat count is reached.
// [R10] Filter mode tests on every later trigger once the repeat count was reached.
// [R11] Channel select is six bits wide and its upper two bits read zero.
// [R12] In right-justified format the high result byte holds result bits 11 to 8 in its low nibble.
// [R13] In right-justified format the low result byte holds result bits 7 to 0.
// [R14] A rising trigger edge, when enabled, sets the conversion start bit in hardware.
// [R15] The mapping of mode codes to modes is a set of package constants.
// [R16] The accumulator is wide enough for the largest repeat count of full-scale results.
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module adc_calc_unit
  import adc_calc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic trigger_i,
  input wire conv_rsp_type conv_i,
  output conv_req_type conv_o,
  output logic irq_o
);
  logic [7:0] ctrl_q;
  logic [7:0] rpt_q;
  logic [7:0] cnt_q;
  logic [5:0] chan_q;
  logic [7:0] resh_q;
  logic [7:0] resl_q;
  logic [ACC_W-1:0] acc_q;
  logic [FILT_W-1:0] filt_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [ACC_W-1:0] thr_q;
  logic go_q;
  logic start_q;
  logic tested_q;
  logic [1:0] left_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic irq_q;
  seq_state_type state_q;

  logic [2:0] mode;
  logic trig_rise;
  logic acc_wr;
  logic [31:0] wmask;
  logic [31:0] rdata_d;
  logic go_wr;
  logic clr_wr;
  logic trig_take;
  logic done_hit;
  logic [7:0] cnt_inc;
  logic reached;
  logic more;
  logic done_evt;
  logic test_evt;
  logic [ACC_W-1:0] test_val;
  logic thr_hit;
  logic [FILT_W:0] filt_diff;
  logic [FILT_W-1:0] filt_d;
  logic [1:0] stat_set;

  edge_sync u_trig_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .async_i(trigger_i),
    .rise_o(trig_rise)
  );

  assign mode = ctrl_q[CTRL_MODE_LSB +: 3];
  // The bus access completes in the cycle where waitrequest is low.
  assign acc_wr = avs_write_i & ~wait_q;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign go_wr = acc_wr && avs_address_i == OFS_CTRL && avs_byteenable_i[1]
                 && avs_writedata_i[CTRL_GO_BIT];
  assign clr_wr = acc_wr && avs_address_i == OFS_CTRL && avs_byteenable_i[0]
                  && avs_writedata_i[CTRL_CLR_BIT];
  assign trig_take = state_q == ST_IDLE
                     && (go_wr || (trig_rise && ctrl_q[CTRL_TRIG_EN_BIT]));
  assign done_hit = state_q == ST_WAIT && conv_i.done;
  assign cnt_inc = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
  assign reached = cnt_inc >= rpt_q;
  assign filt_diff = {1'b0, conv_i.data, 4'h0} - {1'b0, filt_q};
  assign filt_d = filt_q + FILT_W'($signed(filt_diff) >>> LPF_SHIFT);

  always_comb begin
    more = 1'b0;
    done_evt = 1'b0;
    test_evt = 1'b0;
    test_val = acc_q + ACC_W'(conv_i.data);
    if (done_hit) begin
      unique case (mode) // R01 R15
        MODE_BASIC: begin
          more = left_q == 2'h2; // R02
          done_evt = left_q == 2'h1; // R03
          test_evt = left_q == 2'h1;
          test_val = ACC_W'(conv_i.data);
        end
        MODE_ACCUM: begin
          done_evt = 1'b1; // R05
          test_evt = 1'b1; // R05
        end
        MODE_AVG: begin
          done_evt = 1'b1;
          test_evt = reached; // R06
        end
        MODE_BURST: begin
          more = ~reached; // R08
          done_evt = reached;
          test_evt = reached; // R08
        end
        MODE_LPF: begin
          done_evt = 1'b1;
          test_evt = reached; // R09 R10
          test_val = ACC_W'(filt_d[FILT_W-1:4]);
        end
        default: begin
          done_evt = 1'b1;
        end
      endcase
    end
  end

  assign thr_hit = ctrl_q[CTRL_ABOVE_BIT] ? (test_val > thr_q) : (test_val < thr_q);
  assign stat_set = {test_evt & thr_hit, done_evt};

  // Conversion sequencer.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      left_q <= 2'h0;
      go_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (trig_take) begin
        state_q <= ST_WAIT;
        start_q <= 1'b1;
        go_q <= 1'b1; // R14
        left_q <= (mode == MODE_BASIC && ctrl_q[CTRL_DSE_BIT]) ? 2'h2 : 2'h1; // R02
      end else if (done_hit) begin
        if (more) begin
          start_q <= 1'b1;
          left_q <= (left_q == 2'h2) ? 2'h1 : left_q;
        end else begin
          state_q <= ST_IDLE;
          go_q <= 1'b0;
          left_q <= 2'h0;
        end
      end
    end
  end

  // Accumulator, sample count and filter.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= '0;
      cnt_q <= 8'h00;
      filt_q <= '0;
      tested_q <= 1'b0;
    end else if (clr_wr) begin
      acc_q <= '0;
      cnt_q <= 8'h00;
      filt_q <= '0;
      tested_q <= 1'b0;
    end else if (trig_take) begin
      if (mode == MODE_BURST || (mode == MODE_AVG && tested_q)) begin
        acc_q <= '0; // R07 R08
        cnt_q <= 8'h00; // R07
      end
      tested_q <= 1'b0;
    end else if (done_hit) begin
      unique case (mode)
        MODE_ACCUM, MODE_AVG, MODE_BURST: begin
          acc_q <= acc_q + ACC_W'(conv_i.data); // R04 R06 R16
          cnt_q <= cnt_inc; // R04
          tested_q <= mode == MODE_AVG && reached;
        end
        MODE_LPF: begin
          filt_q <= filt_d; // R09 R10
          cnt_q <= cnt_inc;
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // Result byte registers.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resh_q <= 8'h00;
      resl_q <= 8'h00;
    end else if (done_hit) begin
      if (ctrl_q[CTRL_FM_BIT]) begin
        resh_q <= {4'h0, conv_i.data[11:8]}; // R12
        resl_q <= conv_i.data[7:0]; // R13
      end else begin
        resh_q <= conv_i.data[11:4];
        resl_q <= {conv_i.data[3:0], 4'h0};
      end
    end else if (acc_wr && avs_byteenable_i[0]) begin
      if (avs_address_i == OFS_RESH) begin
        resh_q <= avs_writedata_i[7:0];
      end
      if (avs_address_i == OFS_RESL) begin
        resl_q <= avs_writedata_i[7:0];
      end
    end
  end

  // Software configuration registers.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RST;
      rpt_q <= RPT_RST;
      chan_q <= CHAN_RST;
      mask_q <= 2'h0;
      thr_q <= THR_RST;
    end else if (acc_wr) begin
      unique case (avs_address_i)
        OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask[7:0]) | (avs_writedata_i[7:0] & wmask[7:0]
                            & ~(8'h01 << CTRL_CLR_BIT));
        OFS_RPT: rpt_q <= (rpt_q & ~wmask[7:0]) | (avs_writedata_i[7:0] & wmask[7:0]);
        OFS_CHAN: chan_q <= (chan_q & ~wmask[5:0]) | (avs_writedata_i[5:0] & wmask[5:0]);
        OFS_MASK: mask_q <= (mask_q & ~wmask[1:0]) | (avs_writedata_i[1:0] & wmask[1:0]);
        OFS_THR: thr_q <= (thr_q & ~wmask[ACC_W-1:0])
                          | (avs_writedata_i[ACC_W-1:0] & wmask[ACC_W-1:0]);
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Sticky status; a new event in the clearing cycle wins.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= 2'h0;
    end else if (acc_wr && avs_address_i == OFS_STAT && avs_byteenable_i[0]) begin
      stat_q <= (stat_q & ~avs_writedata_i[1:0]) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    unique case (avs_address_i)
      OFS_CTRL: rdata_d = {23'h000000, go_q, ctrl_q};
      OFS_RPT: rdata_d = {24'h000000, rpt_q};
      OFS_CNT: rdata_d = {24'h000000, cnt_q};
      OFS_CHAN: rdata_d = {26'h0000000, chan_q}; // R11
      OFS_RESH: rdata_d = {24'h000000, resh_q};
      OFS_RESL: rdata_d = {24'h000000, resl_q};
      OFS_ACC: rdata_d = {12'h000, acc_q};
      OFS_FILT: rdata_d = {16'h0000, filt_q};
      OFS_STAT: rdata_d = {30'h00000000, stat_q};
      OFS_MASK: rdata_d = {30'h00000000, mask_q};
      OFS_THR: rdata_d = {12'h000, thr_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // One wait cycle per access; read data is captured while waitrequest is high.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
      if (avs_read_i && wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign conv_o.start = start_q;
  assign conv_o.channel = chan_q;
  assign irq_o = irq_q;

  property p_dse_two;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      trig_take && mode == MODE_BASIC && ctrl_q[CTRL_DSE_BIT] |=> left_q == 2'h2 && start_q;
  endproperty
  a_dse_two: assert property (p_dse_two) else $error("double sample not armed"); // R02

  property p_basic_done_last;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      done_hit && mode == MODE_BASIC && left_q == 2'h2 |-> !done_evt ##1 start_q && go_q;
  endproperty
  a_basic_done_last: assert property (p_basic_done_last) else $error("basic ended early"); // R03

  property p_accum_add;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      done_hit && mode == MODE_ACCUM && !clr_wr && cnt_q != 8'hFF
      |=> acc_q == $past(acc_q) + ACC_W'($past(conv_i.data)) && cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_accum_add: assert property (p_accum_add) else $error("accumulate step wrong"); // R04

  property p_accum_done;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      done_hit && mode == MODE_ACCUM |=> stat_q[STAT_DONE_BIT];
  endproperty
  a_accum_done: assert property (p_accum_done) else $error("done flag missing"); // R05

  property p_avg_clear;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      trig_take && mode == MODE_AVG && tested_q && !clr_wr |=> acc_q == '0 && cnt_q == 8'h00;
  endproperty
  a_avg_clear: assert property (p_avg_clear) else $error("average not cleared"); // R07

  property p_burst_run;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      trig_take && mode == MODE_BURST && !clr_wr |=> acc_q == '0 ##0 go_q;
  endproperty
  a_burst_run: assert property (p_burst_run) else $error("burst start wrong"); // R08

  property p_lpf_test;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      done_hit && mode == MODE_LPF && cnt_q >= rpt_q |-> test_evt;
  endproperty
  a_lpf_test: assert property (p_lpf_test) else $error("filter test missing"); // R10

  property p_chan_read;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      avs_read_i && wait_q && avs_address_i == OFS_CHAN |=> avs_readdata_o[31:6] == 26'h0;
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("channel upper bits set"); // R11

  property p_right_just;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      done_hit && ctrl_q[CTRL_FM_BIT]
      |=> resh_q == {4'h0, $past(conv_i.data[11:8])} && resl_q == $past(conv_i.data[7:0]);
  endproperty
  a_right_just: assert property (p_right_just) else $error("result bytes wrong"); // R12 R13

  property p_trig_go;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      state_q == ST_IDLE && trig_rise && ctrl_q[CTRL_TRIG_EN_BIT] |=> go_q ##1 !start_q;
  endproperty
  a_trig_go: assert property (p_trig_go) else $error("trigger did not start"); // R14
endmodule : adc_calc_unit

// ==== core/edge_sync.sv ====
// Two-stage synchroniser with rising-edge detection.
// Assumes the input is asynchronous to sys_clk_i.
`timescale 1ns/10ps
module edge_sync (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic async_i,
  output logic rise_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_o = sync_q & ~last_q;
endmodule : edge_sync

// ==== testbench/conv_core_model.sv ====
// Behavioural model of the analog conversion core on the far side of the unit.
// Assumes the unit keeps at most one conversion outstanding on sys_clk_i.
`timescale 1ns/10ps
module conv_core_model
  import adc_calc_pkg::*;
#(
  parameter int LAT = 3
) (
  input wire logic sys_clk_i,
  input wire conv_req_type req_i,
  input wire logic [RES_W-1:0] sample_i,
  output conv_rsp_type rsp_o
);
  int cnt_q = 0;
  logic [RES_W-1:0] last_q = '0;
  initial rsp_o = '0;
  // Outside the done cycle the data lines carry the inverse of the last result.
  always @(posedge sys_clk_i) begin
    rsp_o.done <= 1'b0;
    rsp_o.data <= ~last_q;
    if (req_i.start === 1'b1) begin
      cnt_q <= LAT;
    end else if (cnt_q == 1) begin
      cnt_q <= 0;
      rsp_o.done <= 1'b1;
      rsp_o.data <= sample_i;
      last_q <= sample_i;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule : conv_core_model

// ==== testbench/testbench.sv ====
// Self-checking bench of the computation unit with a conversion core model.
// Assumes the register map and mode codes of adc_calc_pkg.
`timescale 1ns/10ps
module testbench
  import adc_calc_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic trigger_i = 1'b0;
  conv_rsp_type rsp;
  conv_req_type req;
  logic irq_o;
  logic [RES_W-1:0] sample = '0;
  int err_total = 0;
  int num_checks = 0;
  int starts = 0;
  int cyc = 0;

  adc_calc_unit i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .trigger_i(trigger_i), .conv_i(rsp), .conv_o(req), .irq_o(irq_o));
  conv_core_model i_core (.sys_clk_i(sys_clk_i), .req_i(req), .sample_i(sample), .rsp_o(rsp));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (req.start === 1'b1) starts++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(name, exp, v);
  endtask : rd_chk

  // Writes the configuration, then starts with the go bit and polls busy until it drops.
  // A go write starts with the mode held before that access, so the mode goes first.
  task automatic run(input logic [31:0] c);
    logic [31:0] v;
    int n;
    n = 0;
    wr(OFS_CTRL, c);
    wr(OFS_CTRL, c | 32'h100);
    do begin
      bus(1'b0, OFS_CTRL, 32'h0, v);
      n++;
    end while (v[8] !== 1'b0 && n < 40);
    chk("busy", 32'h0, {31'h0, v[8]});
  endtask : run

  task t_regs;
    rd_chk("ctrl", OFS_CTRL, 32'h0);
    rd_chk("rpt", OFS_RPT, 32'h1);
    rd_chk("chan", OFS_CHAN, 32'h0);
    rd_chk("unmapped", 8'h3C, 32'h0);
    wr(OFS_CHAN, 32'hFF);
    rd_chk("chan", OFS_CHAN, 32'h3F);
    chk("chan_pin", 32'h3F, {26'h0, req.channel});
  endtask : t_regs

  task t_basic;
    int s0;
    sample = 12'hABC;
    s0 = starts;
    run(32'h10);
    chk("starts", s0 + 1, starts);
    rd_chk("resh", OFS_RESH, 32'hA);
    rd_chk("resl", OFS_RESL, 32'hBC);
    wr(OFS_STAT, 32'h3);
    run(32'h18);
    chk("starts", s0 + 3, starts);
    rd_chk("stat", OFS_STAT, 32'h1);
  endtask : t_basic

  task t_accum;
    wr(OFS_THR, 32'h1000);
    wr(OFS_CTRL, 32'h81);
    wr(OFS_STAT, 32'h3);
    sample = 12'h123;
    run(32'h41);
    rd_chk("stat", OFS_STAT, 32'h1);
    rd_chk("cnt", OFS_CNT, 32'h1);
    wr(OFS_STAT, 32'h3);
    sample = 12'hFFF;
    run(32'h41);
    rd_chk("stat", OFS_STAT, 32'h3);
    rd_chk("acc", OFS_ACC, 32'h1122);
    rd_chk("cnt", OFS_CNT, 32'h2);
  endtask : t_accum

  task t_avg;
    wr(OFS_RPT, 32'h2);
    wr(OFS_THR, 32'h300);
    wr(OFS_CTRL, 32'h82);
    wr(OFS_STAT, 32'h3);
    sample = 12'h200;
    run(32'h42);
    rd_chk("stat", OFS_STAT, 32'h1);
    run(32'h42);
    rd_chk("stat", OFS_STAT, 32'h3);
    rd_chk("acc", OFS_ACC, 32'h400);
    wr(OFS_STAT, 32'h3);
    run(32'h42);
    rd_chk("acc", OFS_ACC, 32'h200);
    rd_chk("stat", OFS_STAT, 32'h1);
  endtask : t_avg

  task t_burst;
    int s0;
    wr(OFS_RPT, 32'h3);
    wr(OFS_THR, 32'h3FE);
    wr(OFS_STAT, 32'h3);
    sample = 12'h155;
    s0 = starts;
    run(32'h43);
    chk("starts", s0 + 3, starts);
    rd_chk("acc", OFS_ACC, 32'h3FF);
    rd_chk("stat", OFS_STAT, 32'h3);
  endtask : t_burst

  task t_lpf;
    wr(OFS_RPT, 32'h2);
    wr(OFS_THR, 32'h0);
    wr(OFS_CTRL, 32'h84);
    wr(OFS_STAT, 32'h3);
    sample = 12'h100;
    run(32'h44);
    rd_chk("filt", OFS_FILT, 32'h400);
    rd_chk("stat", OFS_STAT, 32'h1);
    run(32'h44);
    rd_chk("filt", OFS_FILT, 32'h700);
    rd_chk("stat", OFS_STAT, 32'h3);
    wr(OFS_STAT, 32'h3);
    run(32'h44);
    rd_chk("filt", OFS_FILT, 32'h940);
    rd_chk("stat", OFS_STAT, 32'h3);
  endtask : t_lpf

  task t_trig_irq;
    int s0;
    wr(OFS_STAT, 32'h3);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h20);
    s0 = starts;
    trigger_i <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    chk("starts", s0 + 1, starts);
    trigger_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rd_chk("stat", OFS_STAT, 32'h1);
    rd_chk("resh_fm0", OFS_RESH, 32'h10);
    rd_chk("resl_fm0", OFS_RESL, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    wr(OFS_MASK, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    chk("irq_set", 32'h1, {31'h0, irq_o});
    wr(OFS_STAT, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    chk("irq_clr", 32'h0, {31'h0, irq_o});
    wr(OFS_STAT, 32'h3);
    run(32'h05);
    rd_chk("stat_mode5", OFS_STAT, 32'h1);
  endtask : t_trig_irq

  initial begin
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    t_regs();
    t_basic();
    t_accum();
    t_avg();
    t_burst();
    t_lpf();
    t_trig_irq();
    print_verdict();
  end
endmodule : testbench
